/* src/fifo_ctrl_pkg.sv */
// constants, configuration codes and state types of the two-port fifo control
package fifo_ctrl_pkg;
   localparam int DATA_W = 36;
   localparam int OFF_W = 16;
   localparam int ADDR_W_DEF = 10;

   // read width codes
   localparam logic [1:0] RW_FULL = 2'h0;
   localparam logic [1:0] RW_HALF = 2'h1;
   localparam logic [1:0] RW_NINTH = 2'h2;

   localparam logic [DATA_W-1:0] MASK_FULL = 36'hF_FFFF_FFFF;
   localparam logic [DATA_W-1:0] MASK_HALF = 36'h0_0003_FFFF;
   localparam logic [DATA_W-1:0] MASK_NINTH = 36'h0_0000_01FF;

   // default offset table, index {offset_access_select, flag_sel}
   localparam logic [OFF_W-1:0] DEF_OFF_0 = 16'h0007;
   localparam logic [OFF_W-1:0] DEF_OFF_1 = 16'h000F;
   localparam logic [OFF_W-1:0] DEF_OFF_2 = 16'h001F;
   localparam logic [OFF_W-1:0] DEF_OFF_3 = 16'h003F;
   localparam logic [OFF_W-1:0] DEF_OFF_4 = 16'h007F;
   localparam logic [OFF_W-1:0] DEF_OFF_5 = 16'h00FF;
   localparam logic [OFF_W-1:0] DEF_OFF_6 = 16'h01FF;
   localparam logic [OFF_W-1:0] DEF_OFF_7 = 16'h03FF;

   // which offset register the next parallel access touches
   typedef enum logic [1:0] {
      SEL_EMPTY = 2'b01,
      SEL_FULL = 2'b10
   } off_sel_t;

   function automatic logic [OFF_W-1:0] default_offset(input logic [2:0] idx);
      case (idx)
         3'h0: default_offset = DEF_OFF_0;
         3'h1: default_offset = DEF_OFF_1;
         3'h2: default_offset = DEF_OFF_2;
         3'h3: default_offset = DEF_OFF_3;
         3'h4: default_offset = DEF_OFF_4;
         3'h5: default_offset = DEF_OFF_5;
         3'h6: default_offset = DEF_OFF_6;
         default: default_offset = DEF_OFF_7;
      endcase
   endfunction
endpackage

/* src/port_edge.sv */
// rising edge detector with active-low enable for a port clock or strobe pin
`timescale 1ns/1ps
module port_edge (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic pin, // port clock or strobe pin
   input wire logic en_n, // port enable, active low
   output logic rise, // pin rose this cycle
   output logic fire // pin rose with enable active
);
   logic pin_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin;
      end
   end

   assign rise = pin & ~pin_q;
   assign fire = rise & ~en_n;
endmodule

/* src/fifo_ram.sv */
// fifo word storage: one write port, one combinational read port
`timescale 1ns/1ps
module fifo_ram #(
   parameter int AW = 10, // address width
   parameter int DW = 36 // word width
) (
   input wire logic clk, // system clock
   input wire logic we, // write strobe
   input wire logic [AW-1:0] waddr, // write address
   input wire logic [DW-1:0] wdata, // write data
   input wire logic [AW-1:0] raddr, // read address
   output logic [DW-1:0] rdata // read data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule

/* src/fifo_ctrl.sv */
// two-port fifo control: ports, resets, configuration, offsets and flags
`timescale 1ns/1ps
module fifo_ctrl #(
   parameter int AW = fifo_ctrl_pkg::ADDR_W_DEF // log2 of fifo depth
) (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic full_reset_n, // full reset pin, active low
   input wire logic pointer_reset_n, // partial reset pin, active low
   input wire logic wr_port_pin, // write clock or write strobe
   input wire logic wr_en_n, // write enable, active low
   input wire logic [fifo_ctrl_pkg::DATA_W-1:0] din, // write data
   input wire logic rd_port_pin, // read clock or read strobe
   input wire logic rd_en_n, // read enable, active low
   input wire logic offset_access_select_n, // offset access, active low
   input wire logic serial_offset_enable_n, // serial load enable, low
   input wire logic replay_request_n, // retransmit request, active low
   input wire logic mode_serial_in, // early mode strap, then serial in
   input wire logic read_width_select, // width strap
   input wire logic write_width_select, // width strap
   input wire logic width_matching_select, // width strap
   input wire logic flag_timing_select, // flag timing strap
   input wire logic retransmit_latency_select, // replay latency strap
   input wire logic [1:0] flag_sel, // default offset strap
   input wire logic byte_order_select, // byte order strap
   input wire logic parity_place_select, // parity placement strap
   input wire logic wr_port_clocked, // strap: write port clocked
   input wire logic rd_port_clocked, // strap: read port clocked
   output logic [fifo_ctrl_pkg::DATA_W-1:0] dout, // read data
   output logic empty_or_ready_n, // empty flag or output-valid, low
   output logic full_or_space_n, // full flag or space-available, low
   output logic almost_empty_flag, // programmable almost-empty
   output logic almost_full_flag, // programmable almost-full
   output logic cfg_byte_order, // captured byte order
   output logic cfg_parity_place, // captured parity placement
   output logic cfg_wr_clocked // captured write port mode
);
   import fifo_ctrl_pkg::*;

   localparam int PW = AW + 1;
   localparam logic [PW-1:0] DEPTH = PW'(1 << AW);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      gray2bin = b;
   endfunction

   // port edges
   logic wr_rise;
   logic wr_fire;
   logic rd_rise;
   logic rd_fire;

   // captured configuration
   logic early_q;
   logic flag_sync_q;
   logic zero_lat_q;
   logic serial_prog_q;
   logic [1:0] rd_width_q;
   logic byte_order_q;
   logic parity_q;
   logic wr_clocked_q;

   // pointers and their gray copies for the opposite side
   logic [PW-1:0] wptr_q;
   logic [PW-1:0] rptr_q;
   logic [PW-1:0] wgray_q;
   logic [PW-1:0] rgray_q;
   logic [PW-1:0] cnt_r;
   logic [PW-1:0] cnt_w;
   logic [PW-1:0] free_w;

   // output path
   logic [DATA_W-1:0] dout_q;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] width_mask;
   logic ovalid_q;
   logic hold_q;

   // offsets
   logic [OFF_W-1:0] empty_off_q;
   logic [OFF_W-1:0] full_off_q;
   off_sel_t sel_q;

   logic ae_q;
   logic af_q;
   logic ae_live;
   logic af_live;
   logic empty_r;
   logic full_w;
   logic any_reset;
   logic mem_we;
   logic fifo_load;
   logic off_read;
   logic off_pwrite;
   logic serial_shift;
   logic replay;

   port_edge u_wr_edge (
      .clk(clk),
      .resetn(resetn),
      .pin(wr_port_pin),
      .en_n(wr_en_n),
      .rise(wr_rise),
      .fire(wr_fire)
   );

   port_edge u_rd_edge (
      .clk(clk),
      .resetn(resetn),
      .pin(rd_port_pin),
      .en_n(rd_en_n),
      .rise(rd_rise),
      .fire(rd_fire)
   );

   fifo_ram #(
      .AW(AW),
      .DW(DATA_W)
   ) u_ram (
      .clk(clk),
      .we(mem_we),
      .waddr(wptr_q[AW-1:0]),
      .wdata(din),
      .raddr(rptr_q[AW-1:0]),
      .rdata(rdata)
   );

   assign any_reset = ~full_reset_n | ~pointer_reset_n;

   // configuration capture while full reset is held
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         early_q <= 1'b0;
         flag_sync_q <= 1'b0;
         zero_lat_q <= 1'b1;
         serial_prog_q <= 1'b0;
         byte_order_q <= 1'b0;
         parity_q <= 1'b0;
         wr_clocked_q <= 1'b1;
      end else if (!full_reset_n) begin
         early_q <= mode_serial_in & rd_port_clocked;
         flag_sync_q <= flag_timing_select;
         zero_lat_q <= ~retransmit_latency_select;
         serial_prog_q <= offset_access_select_n;
         byte_order_q <= byte_order_select;
         parity_q <= parity_place_select;
         wr_clocked_q <= wr_port_clocked;
      end
   end

   // read width from the three width straps
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_width_q <= RW_FULL;
      end else if (!full_reset_n) begin
         if (!width_matching_select) begin
            rd_width_q <= RW_FULL;
         end else if (write_width_select) begin
            rd_width_q <= RW_FULL;
         end else if (read_width_select) begin
            rd_width_q <= RW_NINTH;
         end else begin
            rd_width_q <= RW_HALF;
         end
      end
   end

   always_comb begin
      case (rd_width_q)
         RW_HALF: width_mask = MASK_HALF;
         RW_NINTH: width_mask = MASK_NINTH;
         default: width_mask = MASK_FULL;
      endcase
   end

   // gray copies carry pointers to the opposite side's flag logic
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wgray_q <= '0;
         rgray_q <= '0;
      end else if (any_reset) begin
         wgray_q <= '0;
         rgray_q <= '0;
      end else begin
         wgray_q <= bin2gray(wptr_q);
         rgray_q <= bin2gray(rptr_q);
      end
   end

   assign cnt_r = gray2bin(wgray_q) - rptr_q;
   assign cnt_w = wptr_q - gray2bin(rgray_q);
   assign free_w = DEPTH - cnt_w;
   assign empty_r = (cnt_r == '0) | hold_q;
   assign full_w = (cnt_w == DEPTH);

   // write side decode
   assign off_pwrite = wr_fire & ~offset_access_select_n & ~serial_prog_q;
   assign mem_we = wr_fire & offset_access_select_n & ~full_w;
   assign serial_shift = wr_rise & ~serial_offset_enable_n & serial_prog_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wptr_q <= '0;
      end else if (any_reset) begin
         wptr_q <= '0;
      end else if (mem_we) begin
         wptr_q <= wptr_q + PTR_ONE;
      end
   end

   // read side decode
   assign replay = rd_rise & ~replay_request_n;
   assign off_read = rd_fire & ~offset_access_select_n;
   assign fifo_load = ~replay & ~empty_r & offset_access_select_n &
      (early_q ? (~ovalid_q | rd_fire) : rd_fire);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rptr_q <= '0;
      end else if (any_reset) begin
         rptr_q <= '0;
      end else if (replay) begin
         rptr_q <= '0;
      end else if (fifo_load) begin
         rptr_q <= rptr_q + PTR_ONE;
      end
   end

   // replay shows empty: one clock at zero latency, else until next read edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hold_q <= 1'b0;
      end else if (any_reset) begin
         hold_q <= 1'b0;
      end else if (replay) begin
         hold_q <= 1'b1;
      end else if (rd_rise | zero_lat_q) begin
         hold_q <= 1'b0;
      end
   end

   // output register and early-mode valid
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dout_q <= '0;
         ovalid_q <= 1'b0;
      end else if (any_reset) begin
         dout_q <= '0;
         ovalid_q <= 1'b0;
      end else if (replay) begin
         ovalid_q <= 1'b0;
      end else if (off_read) begin
         dout_q <= (sel_q == SEL_FULL) ? DATA_W'(full_off_q) :
            DATA_W'(empty_off_q);
      end else if (fifo_load) begin
         dout_q <= rdata & width_mask;
         ovalid_q <= 1'b1;
      end else if (rd_fire) begin
         ovalid_q <= 1'b0;
      end
   end

   // offset registers: defaults at full reset, kept over pointer reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         empty_off_q <= DEF_OFF_0;
         full_off_q <= DEF_OFF_0;
      end else if (!full_reset_n) begin
         empty_off_q <= default_offset({offset_access_select_n, flag_sel});
         full_off_q <= default_offset({offset_access_select_n, flag_sel});
      end else if (serial_shift) begin
         {full_off_q, empty_off_q} <=
            {full_off_q[OFF_W-2:0], empty_off_q, mode_serial_in};
      end else if (off_pwrite) begin
         case (sel_q)
            SEL_EMPTY: empty_off_q <= din[OFF_W-1:0];
            SEL_FULL: full_off_q <= din[OFF_W-1:0];
            default: empty_off_q <= empty_off_q;
         endcase
      end
   end

   // offset register pointer alternates between empty and full offset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_q <= SEL_EMPTY;
      end else if (any_reset) begin
         sel_q <= SEL_EMPTY;
      end else if (off_pwrite | off_read) begin
         case (sel_q)
            SEL_EMPTY: sel_q <= SEL_FULL;
            SEL_FULL: sel_q <= SEL_EMPTY;
            default: sel_q <= SEL_EMPTY;
         endcase
      end
   end

   // programmable flags
   assign ae_live = (OFF_W'(cnt_r) >= empty_off_q) & ~hold_q;
   assign af_live = OFF_W'(free_w) > full_off_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ae_q <= 1'b0;
      end else if (any_reset) begin
         ae_q <= 1'b0;
      end else if (rd_rise) begin
         ae_q <= ae_live;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         af_q <= 1'b1;
      end else if (any_reset) begin
         af_q <= 1'b1;
      end else if (wr_rise) begin
         af_q <= af_live;
      end
   end

   assign almost_empty_flag = flag_sync_q ? ae_q : ae_live;
   assign almost_full_flag = flag_sync_q ? af_q : af_live;
   assign empty_or_ready_n = early_q ? ~ovalid_q : ~empty_r;
   assign full_or_space_n = early_q ? full_w : ~full_w;
   assign dout = dout_q;
   assign cfg_byte_order = byte_order_q;
   assign cfg_parity_place = parity_q;
   assign cfg_wr_clocked = wr_clocked_q;
endmodule

/* sim/port_partner.sv */
// writer and reader logic that drives the port pins of the fifo control
`timescale 1ns/1ps
module port_partner (
   input wire logic clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic wr_go, // request one write edge
   input wire logic rd_go, // request one read edge
   input wire logic wr_dis, // hold write enable off, clocked write port only
   input wire logic strobe_wr, // write port in strobe mode
   output logic wr_port_pin, // write clock or strobe
   output logic rd_port_pin, // read clock or strobe
   output logic wr_en_n, // write enable, active low
   output logic rd_en_n // read enable, active low
);
   // one high cycle per request, low again before the next one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_port_pin <= 1'b0;
         rd_port_pin <= 1'b0;
      end else begin
         wr_port_pin <= wr_go;
         rd_port_pin <= rd_go;
      end
   end
   assign wr_en_n = wr_dis && !strobe_wr;
   assign rd_en_n = 1'b0;
endmodule

/* sim/fifo_ctrl_assertions.sv */
// concurrent checks on the fifo control ports
`timescale 1ns/1ps
module fifo_ctrl_assertions (
   input wire logic clk, // clock
   input wire logic resetn, // reset
   input wire logic full_reset_n, // full reset
   input wire logic pointer_reset_n, // pointer reset
   input wire logic wr_port_pin, // write pin
   input wire logic wr_en_n, // write enable
   input wire logic rd_port_pin, // read pin
   input wire logic offset_access_select_n, // offset access
   input wire logic replay_request_n, // replay
   input wire logic width_matching_select, // width strap
   input wire logic write_width_select, // width strap
   input wire logic read_width_select, // width strap
   input wire logic [fifo_ctrl_pkg::DATA_W-1:0] dout, // read data
   input wire logic empty_or_ready_n, // empty flag
   input wire logic full_or_space_n, // full flag
   input wire logic almost_empty_flag, // almost empty
   input wire logic almost_full_flag // almost full
);
   import fifo_ctrl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_full_clear:
      assert property (!full_reset_n |=> dout == '0)
         else $error("dout kept after full reset");
   a_ptr_clear:
      assert property (!pointer_reset_n |=> dout == '0)
         else $error("dout kept after pointer reset");
   a_dout_stands:
      assert property (full_reset_n && pointer_reset_n &&
         !$rose(rd_port_pin) |=> $stable(dout))
         else $error("dout moved without a read edge");
   a_write_shows:
      assert property ($rose(wr_port_pin) && !wr_en_n &&
         offset_access_select_n && full_or_space_n && full_reset_n &&
         pointer_reset_n && replay_request_n
         |-> ##[1:4] (empty_or_ready_n || !full_reset_n))
         else $error("written word never cleared empty");
   a_replay_empty:
      assert property ($rose(rd_port_pin) && !replay_request_n &&
         full_reset_n && pointer_reset_n |=> !empty_or_ready_n)
         else $error("replay did not show empty");
   a_narrow_zero:
      assert property (full_reset_n && width_matching_select &&
         !write_width_select && read_width_select |-> dout[35:9] == '0)
         else $error("bits above narrow width set");
   a_reset_flags:
      assert property ($rose(full_reset_n) |->
         !almost_empty_flag && almost_full_flag)
         else $error("flags wrong after full reset");
   a_full_flags:
      assert property (!full_or_space_n |-> !almost_full_flag)
         else $error("almost full high while full");
endmodule
bind fifo_ctrl fifo_ctrl_assertions u_chk (.clk, .resetn, .full_reset_n,
   .pointer_reset_n, .wr_port_pin, .wr_en_n, .rd_port_pin,
   .offset_access_select_n, .replay_request_n, .width_matching_select,
   .write_width_select, .read_width_select, .dout, .empty_or_ready_n,
   .full_or_space_n, .almost_empty_flag, .almost_full_flag);

/* sim/fifo_ctrl_tb.sv */
// self-checking bench for the two-port fifo control
`timescale 1ns/1ps
module fifo_ctrl_tb;
   import fifo_ctrl_pkg::*;
   logic clk, resetn, full_reset_n, pointer_reset_n, wr_go, rd_go, wr_dis;
   logic oas_n, soe_n, replay_n, msi, rws, wws, wms, fts, rls, bo, pp;
   logic wpc, rpc, wr_pin, rd_pin, wr_en_n, rd_en_n;
   logic emp_n, ful_n, ae, af, cbo, cpp, cwc;
   logic [1:0] fsel;
   logic [DATA_W-1:0] din, dout;
   int fail_count, checks_done;
   fifo_ctrl #(.AW(4)) dut (.clk(clk), .resetn(resetn),
      .full_reset_n(full_reset_n), .pointer_reset_n(pointer_reset_n),
      .wr_port_pin(wr_pin), .wr_en_n(wr_en_n), .din(din),
      .rd_port_pin(rd_pin), .rd_en_n(rd_en_n),
      .offset_access_select_n(oas_n), .serial_offset_enable_n(soe_n),
      .replay_request_n(replay_n), .mode_serial_in(msi),
      .read_width_select(rws), .write_width_select(wws),
      .width_matching_select(wms), .flag_timing_select(fts),
      .retransmit_latency_select(rls), .flag_sel(fsel),
      .byte_order_select(bo), .parity_place_select(pp),
      .wr_port_clocked(wpc), .rd_port_clocked(rpc), .dout(dout),
      .empty_or_ready_n(emp_n), .full_or_space_n(ful_n),
      .almost_empty_flag(ae), .almost_full_flag(af),
      .cfg_byte_order(cbo), .cfg_parity_place(cpp), .cfg_wr_clocked(cwc));
   port_partner u_far (.clk(clk), .resetn(resetn), .wr_go(wr_go),
      .rd_go(rd_go), .wr_dis(wr_dis), .strobe_wr(!wpc),
      .wr_port_pin(wr_pin), .rd_port_pin(rd_pin), .wr_en_n(wr_en_n),
      .rd_en_n(rd_en_n));
   task print_verdict();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task chk1(input logic a, input logic e);
      checks_done++;
      if (a !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, a, e);
      end
   endtask
   task chkw(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] e);
      checks_done++;
      if (a !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, a, e);
      end
   endtask
   // one port edge; dout is settled when this returns
   task op(input logic w, input logic p, input logic [DATA_W-1:0] d);
      @(posedge clk);
      din <= d;
      wr_go <= w;
      rd_go <= !w;
      replay_n <= !p;
      @(posedge clk);
      wr_go <= 1'b0;
      rd_go <= 1'b0;
      @(posedge clk);
      replay_n <= 1'b1;
      #1;
   endtask
   // pointer copies reach the far side one clock later
   task settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task fr(input logic [6:0] s);
      @(posedge clk);
      {wpc, rls, wms, wws, rws, bo, pp} <= s;
      oas_n <= 1'b0;
      full_reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      full_reset_n <= 1'b1;
      oas_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk1(cbo, s[1]);
      chk1(cpp, s[0]);
      chk1(cwc, s[6]);
   endtask
   task t_reset();
      @(posedge clk);
      #1;
      chkw(dout, '0);
      chk1(emp_n, 1'b0);
      chk1(ful_n, 1'b1);
      chk1(ae, 1'b0);
      chk1(af, 1'b1);
   endtask
   task t_order();
      fr(7'h40);
      @(posedge clk) wr_dis <= 1'b1;
      op(1, 0, 36'hE_EEEE_EEEE);
      @(posedge clk) wr_dis <= 1'b0;
      settle();
      chk1(emp_n, 1'b0);
      for (int i = 0; i < 3; i++) op(1, 0, {32'h9ABC_DEF0, 4'(i)});
      settle();
      chk1(emp_n, 1'b1);
      for (int i = 0; i < 3; i++) begin
         op(0, 0, '0);
         chkw(dout, {32'h9ABC_DEF0, 4'(i)});
      end
      settle();
      chk1(emp_n, 1'b0);
   endtask
   task t_fill();
      fr(7'h41);
      for (int i = 1; i <= 17; i++) begin
         op(1, 0, DATA_W'(i));
         settle();
         case (i)
            6: chk1(ae, 1'b0);
            7: chk1(ae, 1'b1);
            8: chk1(af, 1'b1);
            9: chk1(af, 1'b0);
            16: chk1(ful_n, 1'b0);
            default: ;
         endcase
      end
      for (int i = 1; i <= 17; i++) begin
         op(0, 0, '0);
         chkw(dout, DATA_W'(i > 16 ? 16 : i));
      end
   endtask
   task t_replay();
      fr(7'h40);
      op(1, 0, 36'h1_1111_1111);
      op(1, 0, 36'h2_2222_2222);
      settle();
      op(0, 0, '0);
      op(0, 0, '0);
      op(0, 1, '0);
      chk1(emp_n, 1'b0);
      settle();
      op(0, 0, '0);
      chkw(dout, 36'h1_1111_1111);
   endtask
   task t_offset();
      fr(7'h40);
      @(posedge clk) oas_n <= 1'b0;
      op(1, 0, 36'h2);
      op(1, 0, 36'h3);
      op(0, 0, '0);
      chkw(dout, 36'h2);
      op(0, 0, '0);
      chkw(dout, 36'h3);
      @(posedge clk) oas_n <= 1'b1;
      op(1, 0, 36'h5);
      op(1, 0, 36'h6);
      settle();
      @(posedge clk) pointer_reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      pointer_reset_n <= 1'b1;
      settle();
      chkw(dout, '0);
      chk1(emp_n, 1'b0);
      op(1, 0, 36'h7);
      op(1, 0, 36'h8);
      settle();
      chk1(ae, 1'b1);
   endtask
   task t_narrow();
      fr(7'h16);
      op(1, 0, 36'hF_FFFF_FFFF);
      settle();
      chk1(emp_n, 1'b1);
      op(0, 0, '0);
      chkw(dout, 36'h0_0000_01FF);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end
   initial begin
      fail_count = 0;
      checks_done = 0;
      resetn = 1'b0;
      din = '0;
      {wr_go, rd_go, wr_dis, msi, rws, wws, wms, fts, rls, bo, pp} = '0;
      fsel = 2'h0;
      {full_reset_n, pointer_reset_n, oas_n, soe_n, replay_n} = '1;
      {wpc, rpc} = 2'h3;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_order();
      t_fill();
      t_replay();
      t_offset();
      t_narrow();
      print_verdict();
   end
endmodule
